// ### ecc_counter.v
// ==========================================================
// block overview
// four counting modes share one 24-bit counter register:
//   encoder mode      - up or down on each decoded pulse,
//                       wraps against the period register
//   sensor event mode - up or down on each decoded pulse,
//                       plain sixteen-bit roll-over
//   sensor timer mode - counts every enabled clock, each
//                       pulse restarts it; a compare hit
//                       means the pulse came too late
//   timer mode        - free-running 24-bit up counter
//
// direction comes from a control bit; the phase decoder
// that would normally drive it sits outside this block.
//
// the decoded pulse is asynchronous to the clock, so it
// passes two flip-flops and a rising-edge detector; a
// pulse therefore moves the counter three edges after it
// rises, and a pulse narrower than one clock may be lost.
//
// compare hits are edge triggered: a counter parked on
// the compare value sets the flag once, not every cycle,
// so software can clear it without it coming straight back.
//
// status bits are sticky; a clear written in the same
// cycle as a new event loses, so no event is dropped.
//
// the irq output is registered from status, which adds
// one cycle of lag against the status register, the same as a status read.
//
// the clock enable freezes every flip-flop, the pulse
// synchroniser included; pulses seen while frozen are
// ignored, which keeps the counter consistent with the
// rest of the state when the clock is gated.
//
// register port limits:
//   - no byte lanes; each write replaces a whole word
//   - no wait states; read data stand one cycle only
//   - unmapped reads give zero, unmapped writes vanish
//
// the z-phase enable is stored for software but has no
// effect here; the z-phase logic lives elsewhere.
// ==========================================================
`timescale 1ns/10ps
`include "ecc_map.vh"
module ecc_counter (
  input  wire        mclk_i,
  input  wire        reset_n_i,
  input  wire        clk_en_i,
  input  wire        pulse_tick_i,
  input  wire [7:0]  addr_i,
  input  wire [31:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [31:0] rdata_o,
  output reg         position_compare_irq_o
);

  // ==========================================================
  // register state
  reg [6:0]  ctrl_reg;
  reg [15:0] period_reg;
  reg [23:0] compare_value_register_reg;
  reg [23:0] position_counter_value_reg;
  reg [2:0]  status_reg;
  reg [2:0]  ien_reg;
  reg        tick_s1_reg;
  reg        tick_s2_reg;
  reg        tick_d_reg;

  // ==========================================================
  // decoded controls
  wire [1:0] mode    = ctrl_reg[`ECC_CTRL_MODE_MSB:`ECC_CTRL_MODE_LSB];
  wire       cmpen   = ctrl_reg[`ECC_CTRL_CMPEN];
  wire       inten   = ctrl_reg[`ECC_CTRL_INTEN];
  wire       ccw     = ctrl_reg[`ECC_CTRL_CCW];
  wire       wide    = (mode == `ECC_MODE_STMR) || (mode == `ECC_MODE_TMR);
  // rising edge of the synchronised pulse; the first stage is not looked at
  wire       tick    = tick_s2_reg & ~tick_d_reg;
  wire       wr_cnt  = wr_i && (addr_i == `ECC_ADDR_COUNT);

  // ==========================================================
  // compare operand width follows mode
  function [23:0] cmp_operand;
    input [23:0] v;
    input        w;
    begin
      cmp_operand = w ? v : {`ECC_ZERO8, v[15:0]};
    end
  endfunction

  wire       match = cmpen &&
                     (position_counter_value_reg == cmp_operand(compare_value_register_reg, wide));
  reg        match_d_reg;
  // flag only on the cycle the match begins, so a parked count sets once
  wire       cmp_evt = match && !match_d_reg;
  wire       abn_evt = cmp_evt && (mode == `ECC_MODE_STMR);
  reg        wrap_evt;
  reg [23:0] cnt_next;

  // ==========================================================
  // counter next value per mode
  always @* begin
    cnt_next = position_counter_value_reg;
    wrap_evt = 1'b0;
    case (mode)
      `ECC_MODE_ENC: begin
        if (tick) begin
          if (!ccw) begin
            if (position_counter_value_reg[15:0] >= period_reg) begin
              cnt_next = `ECC_ZERO24;
              wrap_evt = 1'b1;
            end else begin
              cnt_next = {`ECC_ZERO8, position_counter_value_reg[15:0] + 16'h0001};
            end
          end else begin
            if (position_counter_value_reg[15:0] == 16'h0000) begin
              cnt_next = {`ECC_ZERO8, period_reg};
              wrap_evt = 1'b1;
            end else begin
              cnt_next = {`ECC_ZERO8, position_counter_value_reg[15:0] - 16'h0001};
            end
          end
        end
      end
      `ECC_MODE_SEVT: begin
        if (tick) begin
          if (!ccw) begin
            cnt_next = {`ECC_ZERO8, position_counter_value_reg[15:0] + 16'h0001};
          end else begin
            // 16-bit arithmetic rolls zero over to the full maximum
            cnt_next = {`ECC_ZERO8, position_counter_value_reg[15:0] - 16'h0001};
          end
          if (position_counter_value_reg[15:0] == (ccw ? 16'h0000 : `ECC_LO16_MAX)) begin
            wrap_evt = 1'b1;
          end
        end
      end
      `ECC_MODE_STMR: begin
        // measures time between pulses: each pulse restarts the count
        if (tick) begin
          cnt_next = `ECC_ZERO24;
        end else begin
          cnt_next = position_counter_value_reg + 24'h000001;
          wrap_evt = (position_counter_value_reg == `ECC_HI24_MAX);
        end
      end
      `ECC_MODE_TMR: begin
        cnt_next = position_counter_value_reg + 24'h000001; // free run, wraps at max
        wrap_evt = (position_counter_value_reg == `ECC_HI24_MAX);
      end
      default: begin
        cnt_next = position_counter_value_reg;
      end
    endcase
  end

  // ==========================================================
  // pulse input synchroniser
  always @(posedge mclk_i) begin
    if (!reset_n_i) begin
      tick_s1_reg <= 1'b0;
      tick_s2_reg <= 1'b0;
      tick_d_reg  <= 1'b0;
    end else if (clk_en_i) begin
      tick_s1_reg <= pulse_tick_i;
      tick_s2_reg <= tick_s1_reg;
      tick_d_reg  <= tick_s2_reg;
    end
  end

  // ==========================================================
  // configuration registers and counter
  always @(posedge mclk_i) begin
    if (!reset_n_i) begin
      ctrl_reg                   <= 7'h00;
      period_reg                 <= 16'h0000;
      compare_value_register_reg <= `ECC_ZERO24;
      position_counter_value_reg <= `ECC_ZERO24;
      ien_reg                    <= 3'h0;
      match_d_reg                <= 1'b0;
    end else if (clk_en_i) begin
      match_d_reg <= match;
      if (wr_i && addr_i == `ECC_ADDR_CTRL) begin
        ctrl_reg <= wdata_i[6:0];
      end
      if (wr_i && addr_i == `ECC_ADDR_PERIOD) begin
        period_reg <= wdata_i[15:0];
      end
      // whole-word writes only; no byte lanes exist on this port
      if (wr_i && addr_i == `ECC_ADDR_CMPVAL) begin
        compare_value_register_reg <= wdata_i[23:0];
      end
      if (wr_i && addr_i == `ECC_ADDR_IEN) begin
        ien_reg <= wdata_i[2:0];
      end
      // clear bit and direct writes override counting
      if (ctrl_reg[`ECC_CTRL_CLR]) begin
        position_counter_value_reg <= `ECC_ZERO24;
        ctrl_reg[`ECC_CTRL_CLR]    <= 1'b0;
      end else if (wr_cnt) begin
        position_counter_value_reg <= wide ? wdata_i[23:0] : {`ECC_ZERO8, wdata_i[15:0]};
      end else begin
        position_counter_value_reg <= cnt_next;
      end
    end
  end

  // ==========================================================
  // sticky status, set wins over clear; level irq
  always @(posedge mclk_i) begin
    if (!reset_n_i) begin
      status_reg             <= 3'h0;
      position_compare_irq_o <= 1'b0;
    end else if (clk_en_i) begin
      status_reg[`ECC_ST_CMP] <= cmp_evt |
        (status_reg[`ECC_ST_CMP] & ~(wr_i && addr_i == `ECC_ADDR_ICLR && wdata_i[`ECC_ST_CMP]));
      status_reg[`ECC_ST_ABN] <= abn_evt |
        (status_reg[`ECC_ST_ABN] & ~(wr_i && addr_i == `ECC_ADDR_ICLR && wdata_i[`ECC_ST_ABN]));
      status_reg[`ECC_ST_W]   <= wrap_evt |
        (status_reg[`ECC_ST_W] & ~(wr_i && addr_i == `ECC_ADDR_ICLR && wdata_i[`ECC_ST_W]));
      // compare and abnormal sources also need the mode-level enable
      position_compare_irq_o <= |(status_reg & ien_reg & {1'b1, inten, inten});
    end
  end

  // ==========================================================
  // read port, data the cycle after the strobe
  always @(posedge mclk_i) begin
    if (!reset_n_i) begin
      rdata_o <= `ECC_ZERO32;
    end else if (clk_en_i) begin
      rdata_o <= `ECC_ZERO32;
      if (rd_i) begin
        case (addr_i)
          `ECC_ADDR_CTRL:   rdata_o <= {25'h0000000, ctrl_reg};
          `ECC_ADDR_PERIOD: rdata_o <= {16'h0000, period_reg};
          `ECC_ADDR_CMPVAL: rdata_o <= {`ECC_ZERO8, compare_value_register_reg};
          // upper byte reads zero outside the timer modes
          `ECC_ADDR_COUNT:  rdata_o <= {`ECC_ZERO8,
                                        wide ? position_counter_value_reg[23:16] : `ECC_ZERO8,
                                        position_counter_value_reg[15:0]};
          `ECC_ADDR_STATUS: rdata_o <= {29'h00000000, status_reg};
          `ECC_ADDR_IEN:    rdata_o <= {29'h00000000, ien_reg};
          default:          rdata_o <= `ECC_ZERO32;
        endcase
      end
    end
  end

endmodule

// ### ecc_counter_chk.sv
`timescale 1ns/10ps
module ecc_counter_chk (
  input wire        mclk_i,
  input wire        reset_n_i,
  input wire        clk_en_i,
  input wire [7:0]  addr_i,
  input wire [31:0] wdata_i,
  input wire        wr_i,
  input wire        rd_i,
  input wire [31:0] rdata_o,
  input wire        position_compare_irq_o
);
  reg [6:0] ctl_reg;
  reg [2:0] ien_reg;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  // shadow of ctrl and irq enable, so irq causes can be judged
  always @(posedge mclk_i) begin
    if (!reset_n_i) begin
      ctl_reg <= 7'h00;
      ien_reg <= 3'h0;
    end else begin
      if (wr_i && addr_i == 8'h00) ctl_reg <= wdata_i[6:0];
      if (wr_i && addr_i == 8'h14) ien_reg <= wdata_i[2:0];
    end
  end
  sequence s_rd(logic [7:0] a);
    clk_en_i && rd_i && addr_i == a;
  endsequence
  a_rdata_idle: assert property (clk_en_i && !rd_i |=> rdata_o == 32'h0)
    else $error("read data without a read");
  a_reset_quiet: assert property ($rose(reset_n_i) |-> rdata_o == 32'h0 && !position_compare_irq_o)
    else $error("outputs not quiet after reset");
  a_unmapped_zero: assert property (rd_i && addr_i > 8'h18 |=> rdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_count_narrow: assert property (s_rd(8'h0c) ##0 !ctl_reg[1] |=> rdata_o[31:16] == 16'h0)
    else $error("counter wider than 16 bits");
  a_count_top: assert property (s_rd(8'h0c) |=> rdata_o[31:24] == 8'h0)
    else $error("counter wider than 24 bits");
  a_period_width: assert property (s_rd(8'h04) |=> rdata_o[31:16] == 16'h0)
    else $error("period wider than 16 bits");
  a_cmp_width: assert property (s_rd(8'h08) |=> rdata_o[31:24] == 8'h0)
    else $error("compare wider than 24 bits");
  a_irq_cause: assert property ($rose(position_compare_irq_o) |-> ctl_reg[3] || ien_reg[2])
    else $error("irq rose with compare irq disabled");
  a_freeze_hold: assert property (!clk_en_i |=> $stable(rdata_o) && $stable(position_compare_irq_o))
    else $error("outputs moved while clock enable low");
endmodule
bind ecc_counter ecc_counter_chk u_chk (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .position_compare_irq_o(position_compare_irq_o));

// ### ecc_enc_model.sv
`timescale 1ns/10ps
// ==========================================
// encoder side: decoded pulse source
module ecc_enc_model (
  input  wire mclk_i,
  output reg  tick_o
);
  initial tick_o = 1'b0;
  // 3 high, 3 low: long enough for the 2-flop sync, line idles low
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge mclk_i);
      tick_o <= 1'b1;
      repeat (3) @(posedge mclk_i);
      tick_o <= 1'b0;
      repeat (2) @(posedge mclk_i);
    end
  endtask
endmodule

// ### ecc_map.vh
`ifndef ECC_MAP_VH
`define ECC_MAP_VH
// ==========================================================
// register offsets (byte addresses, one word each)
`define ECC_ADDR_CTRL    8'h00
`define ECC_ADDR_PERIOD  8'h04
`define ECC_ADDR_CMPVAL  8'h08
`define ECC_ADDR_COUNT   8'h0c
`define ECC_ADDR_STATUS  8'h10
`define ECC_ADDR_IEN     8'h14
`define ECC_ADDR_ICLR    8'h18
// ==========================================================
// control fields
`define ECC_CTRL_MODE_LSB  0
`define ECC_CTRL_MODE_MSB  1
`define ECC_CTRL_CMPEN     2
`define ECC_CTRL_INTEN     3
`define ECC_CTRL_ZEN       4
`define ECC_CTRL_CCW       5
`define ECC_CTRL_CLR       6
// ==========================================================
// modes
`define ECC_MODE_ENC     2'h0
`define ECC_MODE_SEVT    2'h1
`define ECC_MODE_STMR    2'h2
`define ECC_MODE_TMR     2'h3
// ==========================================================
// status bits
`define ECC_ST_CMP       0
`define ECC_ST_ABN       1
`define ECC_ST_W         2
// ==========================================================
// widths and constants
`define ECC_LO16_MAX     16'hffff
`define ECC_HI24_MAX     24'hffffff
`define ECC_ZERO24       24'h000000
`define ECC_ZERO8        8'h00
`define ECC_ZERO32       32'h00000000
`endif

// ### tb_ecc_counter.sv
`timescale 1ns/10ps
module tb_ecc_counter;
  reg        mclk_i = 1'b0;
  reg        reset_n_i = 1'b0;
  reg [7:0]  addr_i = 8'h00;
  reg [31:0] wdata_i = 32'h0;
  reg        wr_i = 1'b0;
  reg        rd_i = 1'b0;
  reg        clk_en_i = 1'b1;
  wire       tick;
  wire [31:0] rdata_o;
  wire       irq;
  reg [31:0] v;
  reg [71:0] rows [5];
  int        checked = 0;
  int        mismatches = 0;
  int        cyc_cnt = 0;
  ecc_counter u_dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i), .pulse_tick_i(tick),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .position_compare_irq_o(irq));
  ecc_enc_model u_enc (.mclk_i(mclk_i), .tick_o(tick));
  initial forever #50 mclk_i = ~mclk_i;
  // ==========================================
  // bus tasks: full-word accesses only
  task wr(input [7:0] a, input [31:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  task chk(input [31:0] s, input [31:0] e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // read data stand only in the cycle after the strobe
  task rc(input [7:0] a, input [31:0] e);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(posedge mclk_i);
    chk(rdata_o, e);
  endtask
  task print_verdict;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // hang guard, far beyond the few hundred cycles the run needs
  always @(posedge mclk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      mismatches++;
      print_verdict();
    end
  end
  initial begin
    rows = '{{8'h04, 32'habcd1234, 32'h1234}, {8'h08, 32'hff123456, 32'h123456},
      {8'h0c, 32'h00ab1234, 32'h1234}, {8'h10, 32'hff, 32'h0}, {8'h1c, 32'h5, 32'h0}};
    repeat (3) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    rc(8'h0c, 32'h0);
    for (int i = 0; i < 5; i++) begin
      wr(rows[i][71:64], rows[i][63:32]);
      rc(rows[i][71:64], rows[i][31:0]);
    end
    // encoder mode up and down around the period
    wr(8'h04, 32'h2);
    wr(8'h0c, 32'h0);
    u_enc.pulses(2);
    repeat (4) @(posedge mclk_i);
    rc(8'h0c, 32'h2);
    u_enc.pulses(1);
    repeat (4) @(posedge mclk_i);
    rc(8'h0c, 32'h0);
    wr(8'h00, 32'h20);
    u_enc.pulses(1);
    repeat (4) @(posedge mclk_i);
    rc(8'h0c, 32'h2);
    // event mode down through zero, then compare with junk upper bits
    wr(8'h00, 32'h21);
    wr(8'h0c, 32'h0);
    u_enc.pulses(1);
    repeat (4) @(posedge mclk_i);
    rc(8'h0c, 32'hffff);
    wr(8'h14, 32'h3);
    wr(8'h18, 32'h7);
    wr(8'h08, 32'h00ff0005);
    wr(8'h0c, 32'h3);
    wr(8'h00, 32'h0d);
    u_enc.pulses(2);
    repeat (4) @(posedge mclk_i);
    rc(8'h10, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(8'h00, 32'h05);
    repeat (2) @(posedge mclk_i);
    chk({31'h0, irq}, 32'h0);
    // timer mode: lower 16 bits pass first, only the full 24-bit value may hit
    wr(8'h00, 32'h0f);
    wr(8'h0c, 32'h0);
    wr(8'h08, 32'h010030);
    wr(8'h18, 32'h7);
    repeat (60) @(posedge mclk_i);
    rc(8'h10, 32'h0);
    wr(8'h0c, 32'h010020);
    repeat (20) @(posedge mclk_i);
    rc(8'h10, 32'h1);
    chk({31'h0, irq}, 32'h1);
    // sensor timer mode: match also flags abnormal time
    wr(8'h00, 32'h0e);
    wr(8'h0c, 32'h020000);
    wr(8'h08, 32'h020020);
    wr(8'h18, 32'h7);
    repeat (50) @(posedge mclk_i);
    rc(8'h10, 32'h3);
    chk({31'h0, irq}, 32'h1);
    // mid-run reset: all state back to zero
    reset_n_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    rc(8'h0c, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // frozen clock enable: a pulse must not count
    clk_en_i <= 1'b0;
    u_enc.pulses(1);
    repeat (2) @(posedge mclk_i);
    clk_en_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    rc(8'h0c, 32'h0);
    print_verdict();
  end
endmodule
